/* File: rtl/cmc_defs.svh */
// Constants for the control-instruction and console block
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH
// Clock period and storage cycle time in ns
`define CMC_CLK_NS       4
`define CMC_STORE_NS     4000
// Clocks per storage cycle, least time rounded up
`define CMC_STORE_CLKS   ((`CMC_STORE_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
// Opcode field codes (bits 5:0 of the instruction word)
`define CMC_OP_ERR       6'h00
`define CMC_OP_CBC       6'h07
`define CMC_OP_CIL       6'h0b
`define CMC_OP_EXF       6'h3d
`define CMC_OP_HLT       6'h3f
// Instruction field positions
`define CMC_TAG_HI       7
`define CMC_TAG_LO       6
`define CMC_OP_HI        5
`define CMC_OP_LO        0
// Interrupt routine entry address
`define CMC_INT_VEC      12'h001
// Reset values
`define CMC_PC_RST       12'h000
`define CMC_ACC_RST      12'h000
`define CMC_Z_RST        8'h00
`define CMC_TAG_RST      4'h0
// Display selector positions
`define CMC_SEL_UP       2'h1
`define CMC_SEL_CENTER   2'h0
`define CMC_SEL_DOWN     2'h2
`endif

/* File: rtl/cmc_pkg.sv */
// Types shared by the control-instruction and console block
package cmc_pkg;
    // Sequencer states, Gray along fetch, word 2, word 3, equipment wait
    typedef enum logic [2:0] {
        ST_FETCH   = 3'h0,
        ST_WORD2   = 3'h1,
        ST_WORD3   = 3'h3,
        ST_EQUIP   = 3'h2,
        ST_FOREIGN = 3'h6
    } cmc_state_t;
    // Console switches, levels
    typedef struct packed {
        logic       run;
        logic       step;
        logic       lock;
        logic       load;
        logic       enter;
        logic       sweep;
        logic       manual_int;
        logic [1:0] sel8;
        logic [1:0] sel12;
    } cmc_switch_t;
    // Console entry buttons, levels
    typedef struct packed {
        logic       pc_set;
        logic       pc_clr;
        logic       acc_set;
        logic       acc_clr;
        logic       z_set;
        logic       z_clr;
        logic       tag_press;
        logic [1:0] tag_sel;
        logic       tag_set;
        logic       tag_clr;
    } cmc_button_t;
    // Buffer channel state seen by the console
    typedef struct packed {
        logic [7:0]  last_word;
        logic [11:0] cur_addr;
        logic [11:0] limit_addr;
        logic        in_busy;
        logic        out_busy;
    } cmc_buf_t;
    // Status lights; cyc bit 0..3 is cycle A..D
    typedef struct packed {
        logic       run;
        logic       err;
        logic       sel;
        logic       in;
        logic       out;
        logic       buffer_input_light;
        logic       buffer_output_light;
        logic [3:0] cyc;
    } cmc_light_t;
endpackage

/* File: rtl/cmc_control_console.sv */
// Control-instruction sequencer and operator console of a 12-bit computer
`timescale 1ns/1ps
`include "cmc_defs.svh"
module cmc_control_console (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire cmc_pkg::cmc_switch_t sw,
    input  wire cmc_pkg::cmc_button_t btn,
    input  wire logic [11:0]        entry_data,
    input  wire logic               timing_fault,
    input  wire logic               ext_int_req,
    input  wire logic [7:0]         mem_rdata,
    output logic [11:0]             mem_addr,
    output logic [7:0]              mem_wdata,
    output logic                    mem_we,
    output logic [11:0]             func_code,
    output logic                    func_strobe,
    input  wire logic               select_done,
    output logic                    buf_clear,
    input  wire cmc_pkg::cmc_buf_t  buf_state,
    input  wire logic               normal_in_busy,
    input  wire logic               normal_out_busy,
    input  wire logic               tape_valid,
    input  wire logic [7:0]         tape_data,
    input  wire logic               tape_end,
    output logic                    fwd_valid,
    output logic [7:0]              fwd_op,
    input  wire logic               fwd_done,
    input  wire logic [11:0]        fwd_pc,
    output logic [7:0]              disp8,
    output logic [11:0]             disp12,
    output logic [11:0]             disp_acc,
    output logic [1:0]              disp_tag_idx,
    output logic [3:0]              disp_tag,
    output cmc_pkg::cmc_light_t     lights
);
    import cmc_pkg::*;

    localparam logic [11:0] STORE_CLKS = 12'(`CMC_STORE_CLKS);

    cmc_state_t  state;          // Sequencer state
    logic [11:0] pc;             // Program counter
    logic [11:0] acc;            // Accumulator
    logic [7:0]  z;              // Memory data register
    logic [7:0]  ir;             // Current instruction word
    logic [11:0] ret_pc;         // Return address of interrupted program
    logic [5:0]  fc_hi;          // Upper half of the function code
    logic [11:0] exf_pc;         // Address of the select instruction
    logic        lockout;        // Interrupt lockout flip-flop
    logic        int_pend;       // Interrupt waiting to be taken
    logic        halted;         // Stopped by error or halt word, or at tape end
    logic        step_credit;    // One storage cycle granted by step
    logic        step_prev;      // Step switch last cycle
    logic        run_prev;       // Run switch last cycle
    logic        mint_prev;      // Manual interrupt last cycle
    logic [11:0] cnt;            // Storage cycle timer
    logic [3:0]  tags [4];       // Tag registers
    logic        run_mode;       // Machine runs freely
    logic        active;         // Storage cycle timer advances
    logic        cyc_end;        // Last clock of a storage cycle
    logic        console_on;     // Console switches enabled
    logic        take_int;       // Interrupt entered this cycle
    logic        tape_mode;      // Paper tape load in progress

    // Opcode field compare, used by decode and checks
    function automatic logic op_is(input logic [7:0] w, input logic [5:0] code);
        op_is = (w[`CMC_OP_HI:`CMC_OP_LO] == code);
    endfunction

    assign console_on = !sw.lock;
    assign run_mode   = sw.lock || (sw.run && !halted);
    assign tape_mode  = console_on && sw.load && sw.run && !halted;
    assign active     = (run_mode || step_credit) && !tape_mode
                        && state != ST_EQUIP && state != ST_FOREIGN;
    assign cyc_end    = active && (cnt == STORE_CLKS - 12'h001);
    assign take_int   = cyc_end && state == ST_FETCH && int_pend && !lockout
                        && !(console_on && (sw.enter || sw.sweep) && !run_mode);

    // Storage cycle timer
    always_ff @(posedge clk) begin
        if (rst || !active || cyc_end) begin
            cnt <= 12'h000;
        end else begin
            cnt <= cnt + 12'h001;
        end
    end

    // Step edge gives one storage cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            step_prev   <= 1'b0;
            step_credit <= 1'b0;
        end else begin
            step_prev <= sw.step && console_on;
            if (sw.step && console_on && !step_prev && !run_mode) begin
                step_credit <= 1'b1;
            end else if (cyc_end || run_mode) begin
                step_credit <= 1'b0;
            end
        end
    end

    // Tag registers, set or cleared from console when selected
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_tag
            always_ff @(posedge clk) begin
                if (rst) begin
                    tags[gi] <= `CMC_TAG_RST;
                end else if (console_on && btn.tag_press && btn.tag_sel == 2'(gi)) begin
                    if (btn.tag_clr) begin
                        tags[gi] <= `CMC_TAG_RST;
                    end else if (btn.tag_set) begin
                        tags[gi] <= entry_data[3:0];
                    end
                end
            end
        end
    endgenerate

    // Main sequencer: fetch, select words, stops, interrupts, console entry
    always_ff @(posedge clk) begin
        if (rst) begin
            state       <= ST_FETCH;
            pc          <= `CMC_PC_RST;
            acc         <= `CMC_ACC_RST;
            z           <= `CMC_Z_RST;
            ir          <= 8'h00;
            ret_pc      <= `CMC_PC_RST;
            fc_hi       <= 6'h00;
            exf_pc      <= `CMC_PC_RST;
            lockout     <= 1'b0;
            int_pend    <= 1'b0;
            halted      <= 1'b0;
            run_prev    <= 1'b0;
            mint_prev   <= 1'b0;
            mem_addr    <= `CMC_PC_RST;
            mem_wdata   <= 8'h00;
            mem_we      <= 1'b0;
            func_code   <= 12'h000;
            func_strobe <= 1'b0;
            buf_clear   <= 1'b0;
            fwd_valid   <= 1'b0;
            fwd_op      <= 8'h00;
        end else begin
            mem_we      <= 1'b0;
            func_strobe <= 1'b0;
            buf_clear   <= 1'b0;
            run_prev    <= sw.run;
            mint_prev   <= sw.manual_int && console_on;
            mem_addr    <= pc;
            if (sw.run && !run_prev) begin
                halted <= 1'b0;
            end
            if (console_on && !run_mode && state == ST_FETCH) begin
                if (btn.pc_clr) pc <= `CMC_PC_RST;
                else if (btn.pc_set) pc <= entry_data;
                if (btn.acc_clr) acc <= `CMC_ACC_RST;
                else if (btn.acc_set) acc <= entry_data;
                if (btn.z_clr) z <= `CMC_Z_RST;
                else if (btn.z_set) z <= entry_data[7:0];
            end
            if (tape_mode) begin
                if (tape_valid) begin
                    mem_addr  <= pc;
                    mem_wdata <= tape_data;
                    mem_we    <= 1'b1;
                    pc        <= pc + 12'h001;
                end
                if (tape_end) begin
                    halted <= 1'b1;
                end
            end
            case (state)
                ST_FETCH: begin
                    if (take_int) begin
                        ret_pc  <= pc;
                        pc      <= `CMC_INT_VEC;
                        lockout <= 1'b1;
                    end else if (cyc_end && !run_mode && console_on && sw.enter) begin
                        mem_wdata <= acc[7:0];
                        mem_we    <= 1'b1;
                        z         <= acc[7:0];
                        acc       <= `CMC_ACC_RST;
                        pc        <= pc + 12'h001;
                    end else if (cyc_end && !run_mode && console_on && sw.sweep) begin
                        z  <= mem_rdata;
                        pc <= pc + 12'h001;
                    end else if (cyc_end) begin
                        ir <= mem_rdata;
                        z  <= mem_rdata;
                        if (op_is(mem_rdata, `CMC_OP_EXF)) begin
                            exf_pc <= pc;
                            pc     <= pc + 12'h001;
                            state  <= ST_WORD2;
                        end else if (op_is(mem_rdata, `CMC_OP_CIL)) begin
                            lockout <= 1'b0;
                            pc <= mem_rdata[`CMC_TAG_LO] ? ret_pc : pc + 12'h001;
                        end else if (op_is(mem_rdata, `CMC_OP_CBC)) begin
                            buf_clear <= 1'b1;
                            pc        <= pc + 12'h001;
                        end else if (op_is(mem_rdata, `CMC_OP_ERR) ||
                                     op_is(mem_rdata, `CMC_OP_HLT)) begin
                            halted <= 1'b1;
                        end else begin
                            fwd_valid <= 1'b1;
                            fwd_op    <= mem_rdata;
                            state     <= ST_FOREIGN;
                        end
                    end
                end
                ST_WORD2: begin
                    if (cyc_end) begin
                        fc_hi <= mem_rdata[5:0];
                        z     <= mem_rdata;
                        pc    <= pc + 12'h001;
                        state <= ST_WORD3;
                    end
                end
                ST_WORD3: begin
                    if (cyc_end) begin
                        func_code   <= {fc_hi, mem_rdata[5:0]};
                        func_strobe <= 1'b1;
                        z           <= mem_rdata;
                        pc          <= pc + 12'h001;
                        state       <= ST_EQUIP;
                    end
                end
                ST_EQUIP: begin
                    if (select_done) begin
                        state <= ST_FETCH;
                    end
                end
                ST_FOREIGN: begin
                    if (fwd_done) begin
                        fwd_valid <= 1'b0;
                        pc        <= fwd_pc;
                        state     <= ST_FETCH;
                    end
                end
                default: begin
                    state <= ST_FETCH;
                end
            endcase
            if (take_int) begin
                int_pend <= 1'b0;
            end
            if ((sw.manual_int && console_on && !mint_prev) || ext_int_req) begin
                int_pend <= 1'b1;
            end
        end
    end

    // Console displays
    always_ff @(posedge clk) begin
        if (rst) begin
            disp8        <= 8'h00;
            disp12       <= 12'h000;
            disp_acc     <= 12'h000;
            disp_tag_idx <= 2'h0;
            disp_tag     <= 4'h0;
        end else begin
            disp_acc <= acc;
            case (sw.sel8)
                `CMC_SEL_UP:     disp8 <= buf_state.last_word;
                `CMC_SEL_CENTER: disp8 <= z;
                default:         disp8 <= 8'h00;
            endcase
            case (sw.sel12)
                `CMC_SEL_UP:     disp12 <= buf_state.cur_addr;
                `CMC_SEL_CENTER: disp12 <= pc;
                `CMC_SEL_DOWN:   disp12 <= buf_state.limit_addr;
                default:         disp12 <= pc;
            endcase
            if (console_on && btn.tag_press) begin
                disp_tag_idx <= btn.tag_sel;
                disp_tag     <= tags[btn.tag_sel];
            end else begin
                disp_tag_idx <= ir[`CMC_TAG_HI:`CMC_TAG_LO];
                disp_tag     <= tags[ir[`CMC_TAG_HI:`CMC_TAG_LO]];
            end
        end
    end

    // Status lights
    always_ff @(posedge clk) begin
        if (rst) begin
            lights     <= '0;
            lights.cyc <= 4'h8;
            lights.err <= timing_fault;
        end else begin
            lights.run <= run_mode;
            if (timing_fault) lights.err <= 1'b1;
            lights.sel <= (state == ST_WORD3 && cyc_end) ||
                          (state == ST_EQUIP && !select_done);
            lights.in                  <= normal_in_busy;
            lights.out                 <= normal_out_busy;
            lights.buffer_input_light  <= buf_state.in_busy;
            lights.buffer_output_light <= buf_state.out_busy;
            case (state)
                ST_WORD2: lights.cyc <= 4'h1;
                ST_WORD3: lights.cyc <= 4'h2;
                ST_FETCH: lights.cyc <= 4'h8;
                default:  lights.cyc <= 4'h4;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire fetch_end = state == ST_FETCH && cyc_end && !take_int && !sw.enter && !sw.sweep;

    AST_EXF_CODE: assert property ((state == ST_WORD3 && cyc_end) |=>
        func_strobe && func_code == {$past(fc_hi), $past(mem_rdata[5:0])})
        else $error("function code not driven");
    AST_EXF_PC: assert property (state == ST_EQUIP |->
        pc == exf_pc + 12'h003)
        else $error("select does not resume three words on");
    AST_CIL_CLEAR: assert property ((fetch_end && op_is(mem_rdata, `CMC_OP_CIL)) |=>
        !lockout) else $error("lockout not cleared");
    AST_CIL_RET: assert property ((fetch_end && op_is(mem_rdata, `CMC_OP_CIL)
        && mem_rdata[6]) |=> pc == $past(ret_pc))
        else $error("no return to main program");
    AST_CBC_PULSE: assert property ((fetch_end && op_is(mem_rdata, `CMC_OP_CBC)) |=>
        buf_clear ##1 !buf_clear) else $error("buffer clear not one pulse");
    AST_STOP_HOLD: assert property ((fetch_end && op_is(mem_rdata, `CMC_OP_HLT)) |=>
        halted && pc == $past(pc) && $stable(acc)) else $error("halt lost state");
    AST_INT_ENTRY: assert property (take_int |=> lockout && pc == `CMC_INT_VEC)
        else $error("interrupt entry wrong");
    AST_DISP12: assert property (sw.sel12 == `CMC_SEL_DOWN |=>
        disp12 == $past(buf_state.limit_addr)) else $error("limit display wrong");
    AST_CLEAR: assert property (@(posedge clk) disable iff (1'b0) rst |=>
        lights.cyc == 4'h8 && !lockout && pc == `CMC_PC_RST && !int_pend)
        else $error("master clear incomplete");
endmodule

/* File: testbench/cmc_partner.sv */
// Core storage and one peripheral unit facing the console block
`timescale 1ns/1ps
module cmc_partner #(
    parameter logic [11:0] OWN_CODE = 12'h860  // Function code this unit answers
) (
    input  wire logic        clk,
    input  wire logic [11:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_we,
    output logic [7:0]       mem_rdata,
    input  wire logic [11:0] func_code,
    input  wire logic        func_strobe,
    output logic             select_done,
    input  wire logic        fwd_valid,
    output logic             fwd_done,
    output logic [11:0]      fwd_pc
);
    logic [7:0] mem [0:4095];   // Core storage, untouched by master clear
    logic [2:0] delay = 3'h0;   // Unit response countdown

    // Storage read follows the address
    assign mem_rdata = mem[mem_addr];

    // Storage write on the write pulse; the bench preloads this array too
    always @(posedge clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    always @(posedge clk) begin
        if (func_strobe) begin
            delay <= (func_code == OWN_CODE) ? 3'h5 : 3'h0;
        end else if (delay != 3'h0) begin
            delay <= delay - 3'h1;
        end
    end

    // Completion is a one-cycle pulse a few cycles after a matching select,
    // so a stale level can never finish the next select early
    initial select_done = 1'b0;
    always @(posedge clk) begin
        select_done <= !func_strobe && delay == 3'h1;
    end

    // Foreign instructions finish at once and go on at the next word
    initial fwd_done = 1'b0;
    always @(posedge clk) begin
        fwd_done <= fwd_valid && !fwd_done;
        fwd_pc   <= mem_addr + 12'h001;
    end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the control-instruction and console block
`timescale 1ns/1ps
`include "cmc_defs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    import cmc_pkg::*;
    // Display and light case: selectors, busy levels, expected displays
    typedef struct packed {
        logic [1:0]  sel8;
        logic [1:0]  sel12;
        logic [3:0]  busy;   // Normal in, normal out, buffer in, buffer out
        logic [7:0]  exp8;
        logic [11:0] exp12;
    } cmc_row_t;
    logic        clk, rst, timing_fault, ext_int_req, mem_we, func_strobe;
    logic        select_done, buf_clear, normal_in_busy, normal_out_busy;
    logic        tape_valid, tape_end, fwd_valid, fwd_done;
    logic [11:0] entry_data, mem_addr, func_code, fwd_pc, disp12, disp_acc;
    logic [7:0]  mem_rdata, mem_wdata, tape_data, fwd_op, disp8;
    logic [1:0]  disp_tag_idx;
    logic [3:0]  disp_tag;
    cmc_switch_t sw;
    cmc_button_t btn;
    cmc_buf_t    buf_state;
    cmc_light_t  lights;
    int          fails, check_count, n;
    cmc_row_t    rows [3] = '{'{`CMC_SEL_UP, `CMC_SEL_UP, 4'h9, 8'hc6, 12'h2b4},
        '{`CMC_SEL_CENTER, `CMC_SEL_CENTER, 4'h6, 8'h00, 12'h000},
        '{`CMC_SEL_DOWN, `CMC_SEL_DOWN, 4'h0, 8'h00, 12'h7e1}};

    cmc_control_console u_cmc_control_console (
        .clk (clk), .rst (rst), .sw (sw), .btn (btn), .entry_data (entry_data),
        .timing_fault (timing_fault), .ext_int_req (ext_int_req),
        .mem_rdata (mem_rdata), .mem_addr (mem_addr), .mem_wdata (mem_wdata),
        .mem_we (mem_we), .func_code (func_code), .func_strobe (func_strobe),
        .select_done (select_done), .buf_clear (buf_clear), .buf_state (buf_state),
        .normal_in_busy (normal_in_busy), .normal_out_busy (normal_out_busy),
        .tape_valid (tape_valid), .tape_data (tape_data), .tape_end (tape_end),
        .fwd_valid (fwd_valid), .fwd_op (fwd_op), .fwd_done (fwd_done),
        .fwd_pc (fwd_pc), .disp8 (disp8), .disp12 (disp12), .disp_acc (disp_acc),
        .disp_tag_idx (disp_tag_idx), .disp_tag (disp_tag), .lights (lights));

    cmc_partner u_cmc_partner (
        .clk (clk), .mem_addr (mem_addr), .mem_wdata (mem_wdata), .mem_we (mem_we),
        .mem_rdata (mem_rdata), .func_code (func_code), .func_strobe (func_strobe),
        .select_done (select_done), .fwd_valid (fwd_valid), .fwd_done (fwd_done),
        .fwd_pc (fwd_pc));

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Verdict and end of run
    task end_sim;
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A wait that used up its bound ends the run as a mismatch
    task guard(input logic ok);
        if (!ok) begin
            fails++;
            end_sim();
        end
    endtask

    // Main sequence, inputs change on the falling edge
    initial begin
        sw = '0;
        btn = '0;
        entry_data = 12'h000;
        {timing_fault, ext_int_req, tape_valid, tape_end} = 4'h0;
        {normal_in_busy, normal_out_busy} = 2'h0;
        tape_data = 8'h00;
        buf_state = '{8'hc6, 12'h2b4, 12'h7e1, 1'b0, 1'b0};
        rst = 1'b1;
        fails = 0;
        check_count = 0;
        // Program: select 12'h860, clear buffer, clear lockout tag 0, halt
        u_cmc_partner.mem[0] = 8'h3d;
        u_cmc_partner.mem[1] = 8'h21;
        u_cmc_partner.mem[2] = 8'h20;
        u_cmc_partner.mem[3] = 8'h07;
        u_cmc_partner.mem[4] = 8'h0b;
        u_cmc_partner.mem[5] = 8'h3f;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        `CHK(lights.cyc, 4'h8)
        `CHK(func_code, 12'h000)
        // Display selectors and activity lights from the table
        for (int i = 0; i < 3; i++) begin
            sw.sel8 = rows[i].sel8;
            sw.sel12 = rows[i].sel12;
            {normal_in_busy, normal_out_busy} = rows[i].busy[3:2];
            {buf_state.in_busy, buf_state.out_busy} = rows[i].busy[1:0];
            repeat (3) @(negedge clk);
            `CHK(disp8, rows[i].exp8)
            `CHK(disp12, rows[i].exp12)
            `CHK({lights.in, lights.out, lights.buffer_input_light,
                  lights.buffer_output_light}, rows[i].busy)
        end
        // Console entry into the accumulator while stopped
        btn.acc_set = 1'b1;
        entry_data = 12'h5a3;
        repeat (3) @(negedge clk);
        btn.acc_set = 1'b0;
        `CHK(disp_acc, 12'h5a3)
        // Run the program from P
        sw.sel12 = `CMC_SEL_CENTER;
        sw.run = 1'b1;
        for (n = 0; n < 4000 && func_strobe !== 1'b1; n++) @(negedge clk);
        guard(n < 4000);
        `CHK(func_code, 12'h860)
        `CHK(n > 2990 && n < 3010, 1'b1)
        @(negedge clk);
        `CHK(lights.sel, 1'b1)
        repeat (10) @(negedge clk);
        `CHK(lights.sel, 1'b0)
        for (n = 0; n < 1100 && buf_clear !== 1'b1; n++) @(negedge clk);
        `CHK(n < 1100, 1'b1)
        guard(n < 1100);
        // Tag 0 goes on in sequence, then the halt keeps P at its word
        repeat (2100) @(negedge clk);
        `CHK(disp12, 12'h005)
        repeat (1500) @(negedge clk);
        `CHK(disp12, 12'h005)
        `CHK(disp_acc, 12'h5a3)
        `CHK(lights.run, 1'b0)
        // Neutral then run again lets the machine go on
        sw.run = 1'b0;
        repeat (2) @(negedge clk);
        sw.run = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(lights.run, 1'b1)
        sw.run = 1'b0;
        // Timing fault lights the error lamp until a clean master clear
        timing_fault = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(lights.err, 1'b1)
        rst = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(lights.err, 1'b1)
        timing_fault = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(lights.err, 1'b0)
        `CHK(disp_acc, 12'h000)
        // Enter one word by a step, then sweep it back into a cleared Z
        sw.sel8 = `CMC_SEL_CENTER;
        sw.enter = 1'b1;
        btn.pc_set = 1'b1;
        btn.acc_set = 1'b1;
        entry_data = 12'h0a5;
        @(negedge clk);
        btn = '0;
        sw.step = 1'b1;
        repeat (1005) @(negedge clk);
        `CHK(disp12, 12'h0a6)
        `CHK(disp_acc, 12'h000)
        `CHK(disp8, 8'ha5)
        sw.step = 1'b0;
        sw.enter = 1'b0;
        sw.sweep = 1'b1;
        btn.pc_set = 1'b1;
        btn.z_clr = 1'b1;
        @(negedge clk);
        btn = '0;
        sw.step = 1'b1;
        repeat (1005) @(negedge clk);
        `CHK(disp8, 8'ha5)
        `CHK(disp12, 12'h0a6)
        // Manual interrupt is taken at the next stepped fetch
        sw.step = 1'b0;
        sw.sweep = 1'b0;
        sw.manual_int = 1'b1;
        @(negedge clk);
        sw.step = 1'b1;
        repeat (1005) @(negedge clk);
        `CHK(disp12, `CMC_INT_VEC)
        // Tape load puts a tag-one clear-lockout word at P, then stops
        sw.step = 1'b0;
        sw.load = 1'b1;
        sw.run = 1'b1;
        tape_data = 8'h4b;
        tape_valid = 1'b1;
        @(negedge clk);
        tape_valid = 1'b0;
        tape_end = 1'b1;
        @(negedge clk);
        tape_end = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(disp12, 12'h002)
        `CHK(lights.run, 1'b0)
        `CHK(u_cmc_partner.mem[1], 8'h4b)
        // Stepping that word returns to the interrupted address
        sw.load = 1'b0;
        sw.run = 1'b0;
        btn.pc_set = 1'b1;
        entry_data = 12'h001;
        @(negedge clk);
        btn = '0;
        sw.step = 1'b1;
        repeat (1005) @(negedge clk);
        `CHK(disp12, 12'h0a6)
        // Tag entry through a select button, then lock shuts the console out
        btn.tag_press = 1'b1;
        btn.tag_sel = 2'h2;
        btn.tag_set = 1'b1;
        entry_data = 12'h009;
        repeat (3) @(negedge clk);
        `CHK({disp_tag_idx, disp_tag}, 6'h29)
        btn.tag_press = 1'b0;
        btn.tag_set = 1'b0;
        btn.acc_set = 1'b1;
        sw.lock = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(lights.run, 1'b1)
        `CHK(disp_acc, 12'h000)
        end_sim();
    end
endmodule
